/* File: rtl/pcd_pkg.sv */
// constants and types for the post code capture decoder
// Summary of operation
// - every I/O write to diagnostic port 0080h is captured for display
// - word writes to port 80h keep both bytes
// - low byte of a word is the main checkpoint, shown apart
// - high byte upper nibble is function number; 7 add-on ROM, 8 boot-spec ROM
// - high byte lower nibble is bus type, 0 to 5, PCI is 5
// - byte AC flags ACPI mode, AA flags APIC mode
// - bytes 01 to 05 mean entering sleep S1 to S5
// - bytes 10 to 50 mean waking from S1 to S5
package pcd_pkg;
    localparam logic [15:0] PCD_PORT_ADDR = 16'h0080;
    localparam logic [7:0] PCD_CODE_ACPI = 8'hAC;
    localparam logic [7:0] PCD_CODE_APIC = 8'hAA;
    localparam logic [3:0] PCD_SLEEP_MIN = 4'h1;
    localparam logic [3:0] PCD_SLEEP_MAX = 4'h5;
    localparam logic [3:0] PCD_FUNC_MAX = 4'h8;
    localparam logic [3:0] PCD_BUS_MAX = 4'h5;
    localparam logic [15:0] PCD_RESET_CODE = 16'h0000;
    localparam logic [7:0] PCD_HIGH_CLEAR = 8'h00;
    localparam logic [3:0] PCD_NIB_NONE = 4'h0;
    localparam logic [2:0] PCD_STATE_NONE = 3'h0;
    typedef enum logic [3:0] {
        PCD_FN_DISABLE, PCD_FN_STATIC, PCD_FN_OUTPUT, PCD_FN_INPUT,
        PCD_FN_INITIAL_PROGRAM_LOAD, PCD_FN_GENERAL, PCD_FN_ERROR,
        PCD_FN_ADDON_ROM, PCD_FN_BOOT_SPEC_ROM, PCD_FN_UNKNOWN
    } pcd_func_t;
    typedef enum logic [2:0] {
        PCD_BUS_DEVICE_INIT_MANAGER, PCD_BUS_ONBOARD, PCD_BUS_ISA, PCD_BUS_EISA,
        PCD_BUS_ISA_PNP, PCD_BUS_PCI, PCD_BUS_UNKNOWN
    } pcd_bus_t;
endpackage

/* File: rtl/pcd_runtime_decode.sv */
// runtime checkpoint classifier for one captured byte
`timescale 1ns/1ns
module pcd_runtime_decode
    import pcd_pkg::*;
(
    input wire logic [7:0] code,
    output logic is_acpi,
    output logic is_apic,
    output logic is_sleep,
    output logic is_wake,
    output logic [2:0] state_num
);
    wire logic [3:0] lo_nib = code[3:0];
    wire logic [3:0] hi_nib = code[7:4];
    wire logic sleep_hit = (hi_nib == PCD_NIB_NONE) && (lo_nib >= PCD_SLEEP_MIN)
        && (lo_nib <= PCD_SLEEP_MAX);
    wire logic wake_hit = (lo_nib == PCD_NIB_NONE) && (hi_nib >= PCD_SLEEP_MIN)
        && (hi_nib <= PCD_SLEEP_MAX);
    assign is_acpi = (code == PCD_CODE_ACPI);
    assign is_apic = (code == PCD_CODE_APIC);
    assign is_sleep = sleep_hit;
    assign is_wake = wake_hit;
    assign state_num = sleep_hit ? lo_nib[2:0] : (wake_hit ? hi_nib[2:0] : PCD_STATE_NONE);
endmodule

/* File: rtl/pcd_capture.sv */
// post code capture: latches port writes and decodes the checkpoint fields
`timescale 1ns/1ns
module pcd_capture
    import pcd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic io_wr,
    input wire logic [15:0] io_addr,
    input wire logic [15:0] io_wdata,
    input wire logic io_word,
    output logic [7:0] main_code,
    output logic [7:0] high_code,
    output logic word_valid,
    output pcd_func_t func_num,
    output pcd_bus_t bus_type,
    output logic acpi_mode,
    output logic apic_mode,
    output logic sleep_entry,
    output logic wake_exit,
    output logic [2:0] sleep_state,
    output logic capture_pulse
);
    logic [15:0] code_reg;
    logic word_reg;
    logic strobe_reg;
    logic [15:0] code_next;
    wire logic port_hit = io_wr && (io_addr == PCD_PORT_ADDR);
    // a byte write leaves no high byte, so the high fields read as unknown
    assign code_next = io_word ? io_wdata : {PCD_HIGH_CLEAR, io_wdata[7:0]};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            code_reg <= PCD_RESET_CODE;
            word_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= port_hit;
            if (port_hit) begin
                code_reg <= code_next;
                word_reg <= io_word;
            end
        end
    end

    wire logic [3:0] fn_nib = code_reg[15:12];
    wire logic [3:0] bus_nib = code_reg[11:8];
    assign main_code = code_reg[7:0];
    assign high_code = code_reg[15:8];
    assign word_valid = word_reg;
    assign capture_pulse = strobe_reg;
    assign func_num = (word_reg && fn_nib <= PCD_FUNC_MAX) ?
        pcd_func_t'(fn_nib) : PCD_FN_UNKNOWN;
    assign bus_type = (word_reg && bus_nib <= PCD_BUS_MAX) ?
        pcd_bus_t'(bus_nib[2:0]) : PCD_BUS_UNKNOWN;

    // runtime codes are byte writes, so only the main byte is classified
    pcd_runtime_decode u_rt (
        .code(code_reg[7:0]),
        .is_acpi(acpi_mode),
        .is_apic(apic_mode),
        .is_sleep(sleep_entry),
        .is_wake(wake_exit),
        .state_num(sleep_state)
    );

    // capture path: every port write lands one cycle later
    AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        port_hit
        |=> main_code == $past(io_wdata[7:0]))
        else $error("missed capture");

    AST_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        port_hit
        |=> capture_pulse)
        else $error("capture pulse missing");

    AST_NO_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !port_hit
        |=> !capture_pulse)
        else $error("capture pulse without write");

    AST_REFUSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        io_wr && (io_addr != PCD_PORT_ADDR)
        |=> $stable(code_reg))
        else $error("foreign port write captured");

    AST_WORD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        port_hit && io_word
        |=> high_code == $past(io_wdata[15:8]) && word_valid)
        else $error("word high byte lost");

    AST_WORD_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
        port_hit
        |=> word_valid == $past(io_word))
        else $error("word flag wrong");

    // the main byte stands apart: a byte write must not leave a stale high byte
    AST_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
        port_hit && !io_word
        |=> main_code == $past(io_wdata[7:0]) && high_code == PCD_HIGH_CLEAR)
        else $error("main code not shown apart");

    AST_BYTE_FIELDS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !word_valid
        |-> func_num == PCD_FN_UNKNOWN && bus_type == PCD_BUS_UNKNOWN)
        else $error("byte write decoded as word");

    // high byte decode: function nibble and bus nibble
    AST_FUNC: assert property (@(posedge clk_sys) disable iff (!rst_n)
        port_hit && io_word && io_wdata[15:12] == PCD_FUNC_MAX
        |=> func_num == PCD_FN_BOOT_SPEC_ROM)
        else $error("function 8 not decoded");

    for (genvar f = 0; f <= PCD_FUNC_MAX; f++) begin : g_func
        AST_FUNC_EACH: assert property (@(posedge clk_sys) disable iff (!rst_n)
            port_hit && io_word && io_wdata[15:12] == 4'(f)
            |=> func_num == pcd_func_t'(4'(f)))
            else $error("function code not decoded");
    end

    AST_FUNC_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_n)
        port_hit && io_word && io_wdata[15:12] > PCD_FUNC_MAX
        |=> func_num == PCD_FN_UNKNOWN)
        else $error("undefined function accepted");

    AST_BUS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        port_hit && io_word && io_wdata[11:8] == PCD_BUS_MAX
        |=> bus_type == PCD_BUS_PCI)
        else $error("pci bus not decoded");

    for (genvar b = 0; b <= PCD_BUS_MAX; b++) begin : g_bus
        AST_BUS_EACH: assert property (@(posedge clk_sys) disable iff (!rst_n)
            port_hit && io_word && io_wdata[11:8] == 4'(b)
            |=> bus_type == pcd_bus_t'(3'(b)))
            else $error("bus code not decoded");
    end

    AST_BUS_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_n)
        port_hit && io_word && io_wdata[11:8] > PCD_BUS_MAX
        |=> bus_type == PCD_BUS_UNKNOWN)
        else $error("undefined bus accepted");

    // runtime classification of the main byte
    AST_ACPI: assert property (@(posedge clk_sys) disable iff (!rst_n)
        port_hit && io_wdata[7:0] == PCD_CODE_ACPI
        |=> acpi_mode && !apic_mode)
        else $error("acpi code missed");

    AST_APIC: assert property (@(posedge clk_sys) disable iff (!rst_n)
        port_hit && io_wdata[7:0] == PCD_CODE_APIC
        |=> apic_mode && !acpi_mode)
        else $error("apic code missed");

    AST_EXCLUSIVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(acpi_mode && apic_mode)
        && !(sleep_entry && wake_exit))
        else $error("runtime flags overlap");

    AST_SLEEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        port_hit && io_wdata[7:0] == 8'h03
        |=> sleep_entry && sleep_state == 3'h3)
        else $error("sleep s3 missed");

    for (genvar s = PCD_SLEEP_MIN; s <= PCD_SLEEP_MAX; s++) begin : g_sleep
        AST_SLEEP_EACH: assert property (@(posedge clk_sys) disable iff (!rst_n)
            port_hit && io_wdata[7:0] == {PCD_NIB_NONE, 4'(s)}
            |=> sleep_entry && !wake_exit && sleep_state == 3'(s))
            else $error("sleep entry not decoded");
    end

    AST_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        port_hit && io_wdata[7:0] == 8'h50
        |=> wake_exit && sleep_state == 3'h5)
        else $error("wake s5 missed");

    for (genvar w = PCD_SLEEP_MIN; w <= PCD_SLEEP_MAX; w++) begin : g_wake
        AST_WAKE_EACH: assert property (@(posedge clk_sys) disable iff (!rst_n)
            port_hit && io_wdata[7:0] == {4'(w), PCD_NIB_NONE}
            |=> wake_exit && !sleep_entry && sleep_state == 3'(w))
            else $error("wake exit not decoded");
    end

    AST_STATE_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !sleep_entry && !wake_exit
        |-> sleep_state == PCD_STATE_NONE)
        else $error("sleep state without event");

    // display hold and reset clear
    AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !port_hit
        |=> $stable(code_reg))
        else $error("display changed");

    AST_FIELDS_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !port_hit
        |=> $stable(func_num) && $stable(bus_type) && $stable(word_valid))
        else $error("decoded fields changed");

    AST_RUNTIME_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !port_hit
        |=> $stable({acpi_mode, apic_mode, sleep_entry, wake_exit, sleep_state}))
        else $error("runtime flags changed");

    AST_RESET: assert property (@(posedge clk_sys)
        !rst_n
        |=> code_reg == PCD_RESET_CODE)
        else $error("reset not cleared");

    AST_RESET_FLAGS: assert property (@(posedge clk_sys)
        !rst_n
        |=> !word_valid && !capture_pulse)
        else $error("reset left flags set");

    AST_RESET_FIELDS: assert property (@(posedge clk_sys)
        !rst_n
        |=> func_num == PCD_FN_UNKNOWN && bus_type == PCD_BUS_UNKNOWN && !sleep_entry)
        else $error("reset left fields decoded");

    // main scenarios
    COV_WORD: cover property (@(posedge clk_sys) disable iff (!rst_n) port_hit && io_word);
    COV_BYTE: cover property (@(posedge clk_sys) disable iff (!rst_n) port_hit && !io_word);
    COV_ACPI: cover property (@(posedge clk_sys) disable iff (!rst_n) acpi_mode);
    COV_SLEEP: cover property (@(posedge clk_sys) disable iff (!rst_n) sleep_entry);
    COV_WAKE: cover property (@(posedge clk_sys) disable iff (!rst_n) sleep_entry ##[1:20] wake_exit);
endmodule

/* File: testbench/pcd_host_model.sv */
// host firmware model issuing diagnostic port writes
`timescale 1ns/1ns
module pcd_host_model (
    input wire logic clk_sys,
    output logic io_wr,
    output logic [15:0] io_addr,
    output logic [15:0] io_wdata,
    output logic io_word
);
    initial {io_wr, io_addr, io_wdata, io_word} = '0;
    task automatic put(input logic [15:0] a, input logic [15:0] d, input logic w);
        {io_wr, io_addr, io_wdata, io_word} <= {1'b1, a, d, w};
        @(posedge clk_sys);
    endtask
    // critical errors are beeped, never written to the port, so the display keeps its code
    task automatic beep(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // a released bus drops io_wr and shows the inverse of address and data; io_word keeps its stale value
    task automatic idle();
        {io_wr, io_addr, io_wdata} <= {1'b0, ~io_addr, ~io_wdata};
    endtask
endmodule

/* File: testbench/tb_pcd_capture.sv */
// self-checking bench for the post code capture decoder
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t: output differs", $time); end end
module tb_pcd_capture;
    import pcd_pkg::*;
    logic clk_sys, rst_n, io_wr, io_word, word_valid, acpi_mode, apic_mode, lw;
    logic sleep_entry, wake_exit, capture_pulse;
    logic [15:0] io_addr, io_wdata, ld;
    logic [7:0] main_code, high_code;
    logic [2:0] sleep_state;
    logic [31:0] r;
    pcd_func_t func_num;
    pcd_bus_t bus_type;
    int error_cnt = 0, checks_done = 0, cyc = 0, seed = 17;
    pcd_host_model host (.clk_sys(clk_sys), .io_wr(io_wr), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_word(io_word));
    pcd_capture DUT (.clk_sys(clk_sys), .rst_n(rst_n), .io_wr(io_wr), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_word(io_word), .main_code(main_code), .high_code(high_code),
        .word_valid(word_valid), .func_num(func_num), .bus_type(bus_type),
        .acpi_mode(acpi_mode), .apic_mode(apic_mode), .sleep_entry(sleep_entry),
        .wake_exit(wake_exit), .sleep_state(sleep_state), .capture_pulse(capture_pulse));
    function automatic logic [4:0] xr(input logic [7:0] m);
        if (m >= 8'h01 && m <= 8'h05) return {2'b10, m[2:0]};
        if (m[3:0] == 4'h0 && m[7:4] >= 4'h1 && m[7:4] <= 4'h5) return {2'b01, m[6:4]};
        return 5'h00;
    endfunction
    task automatic print_verdict();
        $display("errors %0d, checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic p);
        host.idle();
        #1;
        `CHK(capture_pulse, p)
        `CHK({main_code, high_code, word_valid}, {ld[7:0], lw ? ld[15:8] : 8'h00, lw})
        `CHK(func_num, pcd_func_t'((lw && ld[15:12] <= 4'h8) ? ld[15:12] : 4'h9))
        `CHK(bus_type, pcd_bus_t'((lw && ld[11:8] <= 4'h5) ? ld[10:8] : 3'h6))
        `CHK({acpi_mode, apic_mode}, {ld[7:0] == 8'hAC, ld[7:0] == 8'hAA})
        `CHK({sleep_entry, wake_exit, sleep_state}, xr(ld[7:0]))
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
        host.put(a, d, w);
        if (a === 16'h0080) {ld, lw} = {d, w};
        chk(a === 16'h0080);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (++cyc == 5000) begin error_cnt++; print_verdict(); end
    initial begin
        rst_n = 1'b0;
        {ld, lw} = '0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk(1'b0);
        for (int f = 0; f <= 9; f++) wr(16'h0080, {f[3:0], f[3:0], 8'h38}, 1'b1);
        wr(16'h0080, 16'h5538, 1'b0);
        for (int s = 1; s <= 5; s++) begin
            wr(16'h0080, {8'hFF, 5'h00, s[2:0]}, 1'b0);
            wr(16'h0080, {8'h12, 1'b0, s[2:0], 4'h0}, 1'b1);
        end
        wr(16'h0080, 16'h00AC, 1'b0);
        wr(16'h0080, 16'h00AA, 1'b1);
        wr(16'h0081, 16'h0001, 1'b0);
        host.beep(11);
        chk(1'b0);
        host.put(16'h0080, 16'h1234, 1'b1);
        wr(16'h0080, 16'h5021, 1'b1);
        repeat (300) begin
            r = $random(seed);
            wr(r[0] ? PCD_PORT_ADDR : r[31:16], 16'($random(seed)), r[1]);
        end
        rst_n <= 1'b0;
        @(posedge clk_sys);
        rst_n <= 1'b1;
        {ld, lw} = '0;
        chk(1'b0);
        print_verdict();
    end
endmodule
